//--- design/dmi_chan_evt.v
`timescale 1ns/1ps
`default_nettype none
`include "dmi_map.vh"

module dmi_chan_evt (
	input wire i_core_clk, // system clock
	input wire i_rst_n, // async reset, active low
	input wire i_full_evt, // full pass done pulse
	input wire i_half_evt, // half count pulse
	input wire i_err_evt, // bus error pulse
	input wire [3:0] i_clr, // write-one clear nibble
	input wire [2:0] i_ien, // err, half, full enables
	output wire [3:0] o_flags, // err, half, full, any
	output wire o_irq // channel interrupt
);

reg full_r;
reg half_r;
reg err_r;
wire clr_all;

assign clr_all = i_clr[`DMI_FLD_ANY]; // [RL11]

// sticky flags, a set in the clear cycle wins
always @(posedge i_core_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		full_r <= 1'b0;
		half_r <= 1'b0;
		err_r <= 1'b0;
	end else begin
		if (i_full_evt)
			full_r <= 1'b1; // [RL9]
		else if (i_clr[`DMI_FLD_FULL] | clr_all)
			full_r <= 1'b0; // [RL9] [RL11]
		if (i_half_evt)
			half_r <= 1'b1;
		else if (i_clr[`DMI_FLD_HALF] | clr_all)
			half_r <= 1'b0; // [RL9]
		if (i_err_evt)
			err_r <= 1'b1;
		else if (i_clr[`DMI_FLD_ERR] | clr_all)
			err_r <= 1'b0; // [RL9]
	end
end

// flag nibble with global flag in bit 0
assign o_flags = {err_r, half_r, full_r, full_r | half_r | err_r}; // [RL10]
// any enabled flag raises the line
assign o_irq = (full_r & i_ien[0]) | (half_r & i_ien[1]) |
	(err_r & i_ien[2]); // [RL3]

endmodule // dmi_chan_evt
`default_nettype wire

//--- design/dmi_irq_top.v
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dmi_map.vh"

module dmi_irq_top #(
	parameter NUM_CH = 7,
	parameter [55:0] REQ_MAP = `DMI_MAP_INST0
) (
	input wire i_core_clk, // system clock, 40 MHz
	input wire i_rst_n, // async reset, active low
	input wire i_psel, // apb select
	input wire i_penable, // apb enable
	input wire i_pwrite, // apb direction
	input wire [11:0] i_paddr, // apb byte address
	input wire [31:0] i_pwdata, // apb write data
	output reg [31:0] o_prdata, // apb read data
	output wire o_pready, // apb ready
	output wire o_pslverr, // apb error
	input wire [NUM_CH-1:0] i_cnt_done, // count reached zero
	input wire [NUM_CH-1:0] i_half_cnt, // count at half
	input wire [NUM_CH-1:0] i_bus_err, // bus error response
	input wire [8*NUM_CH-1:0] i_periph_req, // request slots
	output wire [NUM_CH-1:0] o_ch_req, // combined requests
	output wire [NUM_CH-1:0] o_ch_irq, // per-channel irq
	output wire o_irq, // masked summary irq
	output wire [NUM_CH-1:0] o_chan_enable, // channel on
	output wire [NUM_CH-1:0] o_circular_enable, // reload mode
	output wire [15*NUM_CH-1:0] o_ch_ctl // control words
);

localparam FW = `DMI_FLD_W;
localparam SW = FW * NUM_CH;
localparam CW = `DMI_CTL_W;

// summary mask and decode results
reg [SW-1:0] mask_r;
reg [SW-1:0] clr_pulse;
reg [SW-1:0] mask_nxt;
reg [31:0] rd_nxt;
reg addr_ok;
wire [SW-1:0] flag_vec;
wire [NUM_CH-1:0] full_evt;
wire [NUM_CH-1:0] half_evt;
wire setup_ph;
wire access_ph;
wire wr_acc;
wire [4:0] ctl_sel;

// channel index of a control word address, all ones if none
function [4:0] ctl_index;
	input [11:0] addr;
	integer k;
	begin
		ctl_index = 5'h1f;
		for (k = 0; k < NUM_CH; k = k + 1) begin
			if (addr == `DMI_OFS_CTL0 + `DMI_OFS_CTL_STEP * k[11:0])
				ctl_index = k[4:0];
		end
	end
endfunction

// apb phases, zero wait state answer
assign setup_ph = i_psel & ~i_penable;
assign access_ph = i_psel & i_penable;
assign wr_acc = access_ph & i_pwrite;
assign o_pready = access_ph;
assign o_pslverr = access_ph & ~addr_ok;
assign ctl_sel = ctl_index(i_paddr);

// address decode and read mux
integer r;
always @* begin
	addr_ok = 1'b0;
	rd_nxt = `DMI_WORD_RST;
	if (i_paddr == `DMI_OFS_FLAG) begin
		addr_ok = 1'b1;
		rd_nxt[SW-1:0] = flag_vec; // [RL2]
	end else if (i_paddr == `DMI_OFS_CLEAR) begin
		addr_ok = 1'b1;
	end else if (i_paddr == `DMI_OFS_MASK) begin
		addr_ok = 1'b1;
		rd_nxt[SW-1:0] = mask_r;
	end else begin
		for (r = 0; r < NUM_CH; r = r + 1) begin
			if (ctl_sel == r[4:0]) begin
				addr_ok = 1'b1;
				rd_nxt[CW-1:0] = o_ch_ctl[CW*r +: CW];
			end
		end
	end
end

// read data captured in the setup cycle
always @(posedge i_core_clk or negedge i_rst_n) begin
	if (!i_rst_n)
		o_prdata <= `DMI_WORD_RST;
	else if (setup_ph)
		o_prdata <= rd_nxt;
end

// write-one clear strobes, ones only act
always @* begin
	clr_pulse = {SW{1'b0}};
	if (wr_acc && i_paddr == `DMI_OFS_CLEAR)
		clr_pulse = i_pwdata[SW-1:0]; // [RL9] [RL11]
end

// mask register next value, plain write
always @* begin
	mask_nxt = mask_r;
	if (wr_acc && i_paddr == `DMI_OFS_MASK)
		mask_nxt = i_pwdata[SW-1:0];
end

// summary mask register
always @(posedge i_core_clk or negedge i_rst_n) begin
	if (!i_rst_n)
		mask_r <= {SW{1'b0}};
	else
		mask_r <= mask_nxt;
end

// summary interrupt from flag register and mask
assign o_irq = |(flag_vec & mask_r);

genvar g;
generate
	for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
		localparam integer CH_IDX = g;
		reg [CW-1:0] ctl_r;
		reg half_seen_r;
		wire chen;
		assign chen = ctl_r[`DMI_CTL_CHEN];

		// control word, upper fields locked while enabled
		always @(posedge i_core_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				ctl_r <= `DMI_CTL_RST;
			end else if (wr_acc && ctl_sel == CH_IDX[4:0]) begin
				if (!chen)
					ctl_r <= i_pwdata[CW-1:0]; // [RL2]
				else
					ctl_r <= {ctl_r[`DMI_CTL_LOCK_HI:`DMI_CTL_LOCK_LO],
						i_pwdata[`DMI_CTL_LOCK_LO-1:0]};
			end
		end

		// half flag on first arrival at half count
		always @(posedge i_core_clk or negedge i_rst_n) begin
			if (!i_rst_n)
				half_seen_r <= 1'b0;
			else if (i_cnt_done[g] | ~chen)
				half_seen_r <= 1'b0;
			else if (i_half_cnt[g])
				half_seen_r <= 1'b1;
		end
		assign half_evt[g] = i_half_cnt[g] & ~half_seen_r; // [RL13]

		// each pass end sets full, reload or not
		assign full_evt[g] = i_cnt_done[g]; // [RL12]

		// three events into one channel interrupt
		dmi_chan_evt u_evt (
			.i_core_clk(i_core_clk),
			.i_rst_n(i_rst_n),
			.i_full_evt(full_evt[g]),
			.i_half_evt(half_evt[g]),
			.i_err_evt(i_bus_err[g]), // [RL13]
			.i_clr(clr_pulse[FW*g +: FW]),
			.i_ien({ctl_r[`DMI_CTL_ERR_IE], ctl_r[`DMI_CTL_HALF_IE],
				ctl_r[`DMI_CTL_FULL_IE]}),
			.o_flags(flag_vec[FW*g +: FW]), // [RL2] [RL10]
			.o_irq(o_ch_irq[g]) // [RL1] [RL3] [RL4]
		);

		// fixed source table for this channel
		dmi_req_or #(
			.SLOTS(`DMI_SLOTS),
			.SLOT_MASK(REQ_MAP[8*g +: 8])
		) u_req (
			.i_req(i_periph_req[8*g +: 8]), // [RL6] [RL8]
			.o_req(o_ch_req[g]) // [RL5]
		);

		// engine-facing control bits
		assign o_chan_enable[g] = chen;
		assign o_circular_enable[g] = ctl_r[`DMI_CTL_CIRC];
		assign o_ch_ctl[CW*g +: CW] = ctl_r;
	end
endgenerate

endmodule // dmi_irq_top
`default_nettype wire

//--- design/dmi_map.vh
// Functional notes
// (RL1) one interrupt per channel, three event kinds
// (RL2) per event: flag, clear bit, enable bit
// (RL3) channel irq when enabled flag is set
// (RL4) seven channels first instance, five second
// (RL5) requests sharing a channel are ORed
// (RL6) peripherals gate their own requests
// (RL7) software enables one source per channel
// (RL8) fixed per-channel request source tables
// (RL9) flags sticky until write-one clear
// (RL10) channel global flag is OR of flags
// (RL11) global clear wipes all channel flags
// (RL12) circular mode sets full flag each pass
// (RL13) half flag at half count; error on bus error
`ifndef DMI_MAP_VH
`define DMI_MAP_VH

// register byte offsets
`define DMI_OFS_FLAG 12'h000
`define DMI_OFS_CLEAR 12'h004
`define DMI_OFS_CTL0 12'h008
`define DMI_OFS_CTL_STEP 12'h014
`define DMI_OFS_MASK 12'h0a0
`define DMI_ADDR_W 12

// per-channel nibble in flag, clear and mask registers
`define DMI_FLD_W 4
`define DMI_FLD_ANY 0
`define DMI_FLD_FULL 1
`define DMI_FLD_HALF 2
`define DMI_FLD_ERR 3

// control register fields
`define DMI_CTL_W 15
`define DMI_CTL_CHEN 0
`define DMI_CTL_FULL_IE 1
`define DMI_CTL_HALF_IE 2
`define DMI_CTL_ERR_IE 3
`define DMI_CTL_CIRC 5
`define DMI_CTL_LOCK_LO 8
`define DMI_CTL_LOCK_HI 14
`define DMI_CTL_RST 15'h0000

// channel counts and request slots
`define DMI_MAX_CH 7
`define DMI_SLOTS 8

// request slot masks, one byte per channel, channel 0 lowest
`define DMI_MAP_INST0 56'h1f1f3f7f1f1f07
`define DMI_MAP_INST1 56'h00000f0f0f3f1f

`define DMI_WORD_RST 32'h00000000

`endif

//--- design/dmi_req_or.v
`timescale 1ns/1ps
`default_nettype none
`include "dmi_map.vh"

module dmi_req_or #(
	parameter SLOTS = 8,
	parameter [7:0] SLOT_MASK = 8'hff
) (
	input wire [SLOTS-1:0] i_req, // peripheral requests
	output wire o_req // combined channel request
);

// unused slots are masked off, the rest ORed
assign o_req = |(i_req & SLOT_MASK[SLOTS-1:0]); // [RL5] [RL7]

endmodule // dmi_req_or
`default_nettype wire

//--- tb/dmi_irq_props.sv
`timescale 1ns/1ps
`default_nettype none
module dmi_irq_props #(
	parameter NUM_CH = 7
) (
	input wire logic i_core_clk, // clock
	input wire logic i_rst_n, // reset
	input wire logic i_psel, // select
	input wire logic i_penable, // enable
	input wire logic i_pwrite, // write
	input wire logic [11:0] i_paddr, // address
	input wire logic [31:0] i_pwdata, // wdata
	input wire logic o_pready, // ready
	input wire logic [NUM_CH-1:0] i_cnt_done, // done
	input wire logic [NUM_CH-1:0] i_half_cnt, // half
	input wire logic [NUM_CH-1:0] i_bus_err, // error
	input wire logic [NUM_CH-1:0] o_ch_irq, // irqs
	input wire logic [15*NUM_CH-1:0] o_ch_ctl // controls
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);
	// access phase and channel 0 quiet views
	wire acc = i_psel && i_penable;
	wire quiet = !i_cnt_done[0] && !i_half_cnt[0] && !i_bus_err[0];
	sequence s_clr;
		acc && i_pwrite && i_paddr == 12'h004;
	endsequence
	ready_in_access_a: assert property (acc |-> o_pready)
		else $error("no ready");
	ready_outside_a: assert property (!acc |-> !o_pready)
		else $error("stray ready");
	err_irq_a: assert property (!acc && i_bus_err[0] && o_ch_ctl[3]
		|=> o_ch_irq[0]) else $error("error gave no irq");
	full_irq_a: assert property (!acc && i_cnt_done[0] && o_ch_ctl[1]
		|=> o_ch_irq[0]) else $error("done gave no irq");
	irq_needs_enable_a: assert property (o_ch_irq[0] |-> |o_ch_ctl[3:1])
		else $error("irq without enable");
	irq_holds_a: assert property (o_ch_irq[0] && !acc |=> o_ch_irq[0])
		else $error("flag lost");
	zero_clear_a: assert property (s_clr ##0 i_pwdata[3:0] == 4'h0
		##0 o_ch_irq[0] |=> o_ch_irq[0]) else $error("zero cleared");
	global_clear_a: assert property (s_clr ##0 i_pwdata[0] ##0 quiet
		|=> !o_ch_irq[0]) else $error("global clear missed");
endmodule // dmi_irq_props
bind dmi_irq_top dmi_irq_props #(.NUM_CH(NUM_CH)) dmi_irq_props_inst (
	.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_pready(o_pready), .i_cnt_done(i_cnt_done),
	.i_half_cnt(i_half_cnt), .i_bus_err(i_bus_err), .o_ch_irq(o_ch_irq),
	.o_ch_ctl(o_ch_ctl));
`default_nettype wire

//--- tb/dmi_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmi_periph_model (
	input wire logic [7:0] i_slot, // one-hot enabled source
	input wire logic [6:0] i_level, // per-channel demand
	output logic [55:0] o_req // request slots
);
	// each source gated by its own enable, one per channel
	always_comb begin
		for (int g = 0; g < 7; g++)
			o_req[8*g +: 8] = i_slot & {8{i_level[g]}};
	end
endmodule // dmi_periph_model
`default_nettype wire

//--- tb/test_dma_channel_irq_and_request_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmi_map.vh"
module test_dma_channel_irq_and_request_map;
	logic i_core_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0;
	logic i_pwrite = 0, se;
	logic [11:0] i_paddr = 0;
	logic [31:0] i_pwdata = 0, rd, msk = 0, seed = 32'h00002422;
	logic [6:0] i_cnt_done = 0, i_half_cnt = 0, i_bus_err = 0, lvl = 0, q;
	logic [7:0] slot = 8'h01;
	logic [55:0] preq;
	wire [31:0] o_prdata;
	wire o_pready, o_pslverr, o_irq;
	wire [6:0] o_ch_req, o_ch_irq;
	wire [104:0] o_ch_ctl;
	wire [6:0] o_chan_enable, o_circular_enable;
	wire [4:0] req5;
	logic [4:0] q5;
	int cnt1[5] = '{5, 6, 4, 4, 4};
	int err_count = 0, n_compared = 0, flg[7], ien[7], g, k;
	int cnt[7] = '{3, 5, 5, 7, 6, 5, 5};
	dmi_irq_top dmi_irq_top_inst (.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_cnt_done(i_cnt_done), .i_half_cnt(i_half_cnt),
		.i_bus_err(i_bus_err), .i_periph_req(preq), .o_ch_req(o_ch_req),
		.o_ch_irq(o_ch_irq), .o_irq(o_irq),
		.o_chan_enable(o_chan_enable),
		.o_circular_enable(o_circular_enable), .o_ch_ctl(o_ch_ctl));
	dmi_periph_model dmi_periph_model_inst (.i_slot(slot), .i_level(lvl),
		.o_req(preq));
	// five-channel controller sharing the bus and the events
	if (1) begin : g_five
		dmi_irq_top #(.NUM_CH(5), .REQ_MAP(`DMI_MAP_INST1))
			dmi_irq_top_inst (.i_core_clk(i_core_clk),
			.i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
			.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
			.o_prdata(), .o_pready(), .o_pslverr(),
			.i_cnt_done(i_cnt_done[4:0]), .i_half_cnt(i_half_cnt[4:0]),
			.i_bus_err(i_bus_err[4:0]), .i_periph_req(preq[39:0]),
			.o_ch_req(req5), .o_ch_irq(), .o_irq(), .o_chan_enable(),
			.o_circular_enable(), .o_ch_ctl());
	end
	// clock generator
	always #12.5 i_core_clk = ~i_core_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h not %h", $time, got, exp);
		end
	endtask
	task automatic cmp_line(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: lines %b not %b", $time, got, exp);
		end
	endtask
	// one apb transfer, held until ready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_core_clk);
		i_penable <= 1;
		do @(posedge i_core_clk); while (o_pready !== 1'b1);
		rd = o_prdata;
		se = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
		@(posedge i_core_clk);
	endtask
	// one-cycle event pulse of kind k on channel c
	task automatic ev(input int k, input int c);
		case (k)
			0: i_cnt_done[c] <= 1;
			1: i_half_cnt[c] <= 1;
			default: i_bus_err[c] <= 1;
		endcase
		@(posedge i_core_clk);
		i_cnt_done <= 0;
		i_half_cnt <= 0;
		i_bus_err <= 0;
		@(posedge i_core_clk);
		flg[c] |= 1 << k;
	endtask
	// flag word, channel irqs and summary irq against the model
	task automatic check();
		logic [31:0] e;
		e = 0;
		for (int c = 0; c < 7; c++) begin
			e[4*c +: 4] = {flg[c][2:0], flg[c] != 0};
			q[c] = (flg[c] & ien[c]) != 0;
		end
		apb(0, 12'h000, 0);
		cmp_word(rd, e);
		cmp_line(o_ch_irq, q);
		cmp_line(o_irq, |(e & msk));
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// watchdog
	initial begin
		#1000000;
		err_count++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		repeat (8) @(posedge i_core_clk);
		i_rst_n <= 1;
		@(posedge i_core_clk);
		cmp_line(o_ch_irq, 8'h00);
		apb(1, 12'h0fc, 32'hffffffff);
		apb(0, 12'h0fc, 0);
		cmp_word({rd[30:0], se}, 1);
		for (g = 0; g < 7; g++) begin
			ien[g] = g ? rnd() & 7 : 7;
			msk = rnd() & 32'h0fffffff;
			apb(1, 12'h0a0, msk);
			apb(1, 12'(8 + 20 * g), ien[g] << 1);
			for (k = 0; k < 3; k++) begin
				ev(k, g);
				check();
			end
			apb(1, 12'h004, 0);
			check();
			apb(1, 12'h004, 32'h2 << 4 * g);
			flg[g] &= 6;
			check();
			apb(1, 12'h004, 32'h1 << 4 * g);
			flg[g] = 0;
			check();
		end
		apb(0, 12'h004, 0);
		cmp_word(rd, 0);
		// control word readback, upper field locked while enabled
		apb(1, 12'h008, 32'h00002a21);
		apb(0, 12'h008, 0);
		cmp_word(rd, 32'h00002a21);
		cmp_line({o_chan_enable[0], o_circular_enable[0]}, 8'h03);
		apb(1, 12'h008, 32'h00007f20);
		apb(0, 12'h008, 0);
		cmp_word(rd, 32'h00002a20);
		cmp_line({o_chan_enable[0], o_circular_enable[0]}, 8'h01);
		for (k = 0; k < 24; k++) begin
			slot <= 8'h1 << (rnd() % 8);
			lvl <= 7'(rnd());
			@(posedge i_core_clk);
			for (g = 0; g < 7; g++)
				q[g] = lvl[g] && slot < (8'h1 << cnt[g]);
			for (g = 0; g < 5; g++)
				q5[g] = lvl[g] && slot < (8'h1 << cnt1[g]);
			cmp_line(o_ch_req, q);
			cmp_line(req5, q5);
		end
		tally_and_finish();
	end
endmodule // test_dma_channel_irq_and_request_map
`default_nettype wire
